/* logic/gpio_pin_pkg.sv */
// Purpose: Constants and types shared by the per-pin control block and its testbench.
// Assumes: One pin, one 25 MHz core clock, registers reached over a plain strobe port.
// Notes:   The control byte keeps the documented field layout; other registers are local.
//
// Function
// R1: The pin function comes from the three-bit select field plus the pulse enable, direction and value bits.
// R2: As an output, the select field picks the toggle rate of the driver so that an LED flashes.
// R3: The per-pin direction and value bits drive this pin directly instead of byte-wide registers.
// R4: A cleared direction bit makes the pin an output.
// R5: A set direction bit releases the driver and makes the pin an input.
// R6: The six control bits pick one of seven flash rates, one of eight pulse trains, or steady on or off.
// R7: While flashing, the pin drives only high (open-source) or only low (open-drain).
// R8: As an input, the select field picks which edge raises an interrupt condition.
// R9: Pin changes pass a transition filter and only filtered transitions count.
// R10: A valid selected input transition asserts the active-low interrupt output.
// R11: The same transition loads the source status register with this pin's control address.
// R12: Software changes direction and enables the interrupt in separate writes.
// R13: With the pulse enable set, the select field picks one of eight pulse-train circuits.
// R14: As an output, the written value bit is the level driven on the pin.
// R15: After reset the direction bit is one, so the pin starts as an input with a weak pull-up.
// R16: The filter takes a new level only after two consecutive equal samples.
package gpio_pin_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] SRC_OFS      = 8'h0C;

  // Control byte layout.
  localparam int CTRL_TRAIN_BIT = 7;
  localparam int CTRL_SEL_HI    = 4;
  localparam int CTRL_SEL_LO    = 2;
  localparam int CTRL_DIR_BIT   = 1;
  localparam int CTRL_VALUE_BIT = 0;

  // Direction and value come up set; bypass bits 6:5 are not kept and read as zero.
  localparam logic [DATA_W-1:0] CTRL_RESET   = 8'h03;
  localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'h9F;
  localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;

  // Interrupt status and mask layout.
  localparam int IRQ_EDGE_BIT = 0;

  // Select code that means steady drive of the value bit.
  localparam logic [2:0] SEL_STEADY = 3'h0;

  // Flash prescaler: rate k follows counter bit FLASH_BIT_BASE + k.
  localparam int FLASH_CNT_W    = 24;
  localparam int FLASH_BIT_BASE = 15;
  localparam logic [FLASH_CNT_W-1:0] FLASH_ONE = 24'h00_0001;

  // Edge selection while the pin is an input.
  typedef enum logic [2:0] {
    EDGE_NONE = 3'b000,
    EDGE_RISE = 3'b001,
    EDGE_FALL = 3'b010,
    EDGE_ANY  = 3'b011
  } edge_sel_t;

endpackage

/* logic/pin_edge_filter.sv */
// Purpose: Transition filter for the pin input with rise and fall event pulses.
// Assumes: The pin input is already synchronous to i_clk.
// Notes:   A glitch shorter than two samples never reaches the filtered level.
`timescale 1ns/1ps
module pin_edge_filter (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic sample_q;
  logic level_q;
  logic rise_q;
  logic fall_q;

  // Previous sample, compared against the current one.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sample_q <= 1'b1;
    end else begin
      sample_q <= i_pin;
    end
  end

  // Accept a level only when two consecutive samples agree; reset matches the pull-up.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_q <= 1'b1;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (i_pin == sample_q && i_pin != level_q) begin // R16
        level_q <= i_pin;
        rise_q  <= i_pin;
        fall_q  <= !i_pin;
      end
    end
  end

  assign o_level = level_q;
  assign o_rise  = rise_q;
  assign o_fall  = fall_q;

  property p_stable_two;
    @(posedge i_clk) disable iff (!i_rst_n)
      $changed(level_q) |-> ($past(i_pin, 1) == level_q) && ($past(i_pin, 2) == level_q);
  endproperty
  a_stable_two: assert property (p_stable_two) else $error("filter took an unstable level"); // R16

endmodule

/* logic/gpio_pin_ctrl.sv */
// Purpose: Per-pin function select, LED flash drive and edge interrupt for one I/O pin.
// Assumes: Pin input synchronous to i_clk; pulse-train generators live outside this block.
// Notes:   Pin drive is registered, so a control write reaches the pin two edges later.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module gpio_pin_ctrl #(
  parameter logic [7:0] SRC_ADDR = 8'h90
) (
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_n,
  input  wire logic [gpio_pin_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [gpio_pin_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                           i_wr_en,
  input  wire logic                           i_rd_en,
  output logic      [gpio_pin_pkg::DATA_W-1:0] o_rdata,
  input  wire logic [7:0]                     i_pulse_train,
  input  wire logic                           i_pin_in,
  output logic                                o_pin_out,
  output logic                                o_pin_oe,
  output logic                                o_pull_up_en,
  output logic                                o_int_n
);

  logic [gpio_pin_pkg::DATA_W-1:0]      ctrl_q;
  logic [gpio_pin_pkg::DATA_W-1:0]      status_q;
  logic [gpio_pin_pkg::DATA_W-1:0]      mask_q;
  logic [gpio_pin_pkg::DATA_W-1:0]      src_q;
  logic [gpio_pin_pkg::FLASH_CNT_W-1:0] flash_cnt_q;
  logic [gpio_pin_pkg::DATA_W-1:0]      rdata_q;
  logic                                 pin_out_q;
  logic                                 pin_oe_q;
  logic                                 pull_up_q;
  logic                                 int_n_q;

  logic       pulse_train_enable;
  logic [2:0] pin_function_select;
  logic       pin_direction_bit;
  logic       pin_output_value;
  logic       pin_out_d;
  logic       pin_oe_d;
  logic       pull_up_d;
  logic       flash_phase_now;
  logic       filt_level;
  logic       filt_rise;
  logic       filt_fall;
  logic       sel_edge;
  logic       stat_clear;
  logic       wr_ctrl;

  // Pick the prescaler bit that paces the chosen flash rate.
  function automatic logic flash_phase(input logic [gpio_pin_pkg::FLASH_CNT_W-1:0] cnt,
                                       input logic [2:0] rate);
    int idx;
    idx = gpio_pin_pkg::FLASH_BIT_BASE + int'(rate);
    return cnt[idx];
  endfunction

  // Field views of the control byte.
  assign pulse_train_enable  = ctrl_q[gpio_pin_pkg::CTRL_TRAIN_BIT];
  assign pin_function_select = ctrl_q[gpio_pin_pkg::CTRL_SEL_HI:gpio_pin_pkg::CTRL_SEL_LO];
  assign pin_direction_bit   = ctrl_q[gpio_pin_pkg::CTRL_DIR_BIT];
  assign pin_output_value    = ctrl_q[gpio_pin_pkg::CTRL_VALUE_BIT];
  assign wr_ctrl             = i_wr_en && (i_addr == gpio_pin_pkg::CTRL_OFS);

  // Control byte; this pin's own direction, value, select and pulse-train bits are its only controls.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= gpio_pin_pkg::CTRL_RESET; // R15
    end else if (wr_ctrl) begin
      ctrl_q <= i_wdata & gpio_pin_pkg::CTRL_WR_MASK; // R3
    end
  end

  // Free-running prescaler shared by all flash rates.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flash_cnt_q <= '0;
    end else begin
      flash_cnt_q <= flash_cnt_q + gpio_pin_pkg::FLASH_ONE;
    end
  end

  assign flash_phase_now = flash_phase(flash_cnt_q, pin_function_select);

  // Decode the six control bits into the pin drive.
  always_comb begin
    pin_out_d = pin_output_value;
    pin_oe_d  = 1'b0;
    pull_up_d = 1'b0;
    if (pin_direction_bit) begin // R1
      pull_up_d = 1'b1; // R5
    end else if (pulse_train_enable) begin // R4
      pin_out_d = i_pulse_train[pin_function_select]; // R13
      pin_oe_d  = 1'b1;
    end else if (pin_function_select == gpio_pin_pkg::SEL_STEADY) begin // R6
      pin_out_d = pin_output_value; // R14
      pin_oe_d  = 1'b1;
    end else begin
      // The value bit picks the flash style, since a one-sided driver needs no data.
      pin_out_d = pin_output_value; // R7
      pin_oe_d  = flash_phase_now; // R2
    end
  end

  // Pin drive comes straight from flip-flops; a pin set as input is pulled up.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_out_q <= 1'b1;
      pin_oe_q  <= 1'b0;
      pull_up_q <= 1'b1;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
      pull_up_q <= pull_up_d;
    end
  end

  pin_edge_filter u_filter (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_pin_in), // R9
    .o_level (filt_level),
    .o_rise  (filt_rise),
    .o_fall  (filt_fall)
  );

  // Match filtered edges against the selected kind; codes above EDGE_ANY never fire.
  always_comb begin
    sel_edge = 1'b0;
    if (pin_direction_bit) begin
      unique case (pin_function_select) // R8
        gpio_pin_pkg::EDGE_NONE: sel_edge = 1'b0;
        gpio_pin_pkg::EDGE_RISE: sel_edge = filt_rise;
        gpio_pin_pkg::EDGE_FALL: sel_edge = filt_fall;
        gpio_pin_pkg::EDGE_ANY:  sel_edge = filt_rise || filt_fall;
        default:                 sel_edge = 1'b0;
      endcase
    end
  end

  assign stat_clear = i_wr_en && (i_addr == gpio_pin_pkg::IRQ_STAT_OFS) &&
                      i_wdata[gpio_pin_pkg::IRQ_EDGE_BIT];

  // Sticky event bit, write one to clear; a same-cycle event wins over the clear.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_q <= gpio_pin_pkg::ZERO_BYTE;
    end else if (sel_edge) begin
      status_q[gpio_pin_pkg::IRQ_EDGE_BIT] <= 1'b1; // R10
    end else if (stat_clear) begin
      status_q[gpio_pin_pkg::IRQ_EDGE_BIT] <= 1'b0;
    end
  end

  // Interrupt mask; only the event bit is kept, others read as zero.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_q <= gpio_pin_pkg::ZERO_BYTE;
    end else if (i_wr_en && i_addr == gpio_pin_pkg::IRQ_MASK_OFS) begin
      mask_q[gpio_pin_pkg::IRQ_EDGE_BIT] <= i_wdata[gpio_pin_pkg::IRQ_EDGE_BIT];
    end
  end

  // Source register names the control register of the pin that fired.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_q <= gpio_pin_pkg::ZERO_BYTE;
    end else if (sel_edge) begin
      src_q <= SRC_ADDR; // R11
    end
  end

  // Level interrupt, low while an unmasked event is pending.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= !(|(status_q & mask_q)); // R10
    end
  end

  // Read port: data stand one cycle after the strobe; unmapped reads return zero.
  // As an input, the value bit reads the filtered pin level rather than the stored bit.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= gpio_pin_pkg::ZERO_BYTE;
    end else if (i_rd_en) begin
      unique case (i_addr)
        gpio_pin_pkg::CTRL_OFS: begin
          rdata_q <= ctrl_q;
          rdata_q[gpio_pin_pkg::CTRL_VALUE_BIT] <= pin_direction_bit ? filt_level
                                                                     : pin_output_value;
        end
        gpio_pin_pkg::IRQ_STAT_OFS: rdata_q <= status_q;
        gpio_pin_pkg::IRQ_MASK_OFS: rdata_q <= mask_q;
        gpio_pin_pkg::SRC_OFS:      rdata_q <= src_q;
        default:                    rdata_q <= gpio_pin_pkg::ZERO_BYTE;
      endcase
    end else begin
      rdata_q <= gpio_pin_pkg::ZERO_BYTE;
    end
  end

  assign o_rdata      = rdata_q;
  assign o_pin_out    = pin_out_q;
  assign o_pin_oe     = pin_oe_q;
  assign o_pull_up_en = pull_up_q;
  assign o_int_n      = int_n_q;

  // Checks on the pin drive and the interrupt path.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_input_released;
    pin_direction_bit |=> !o_pin_oe && o_pull_up_en;
  endproperty
  a_input_released: assert property (p_input_released) else $error("input pin is driven"); // R5

  property p_output_steady;
    !pin_direction_bit && !pulse_train_enable && pin_function_select == gpio_pin_pkg::SEL_STEADY
      |=> o_pin_oe && (o_pin_out == $past(pin_output_value));
  endproperty
  a_output_steady: assert property (p_output_steady) else $error("steady drive wrong"); // R14

  property p_one_sided;
    !pin_direction_bit && !pulse_train_enable && pin_function_select != gpio_pin_pkg::SEL_STEADY
      |=> (o_pin_out == $past(pin_output_value)) && (o_pin_oe == $past(flash_phase_now));
  endproperty
  a_one_sided: assert property (p_one_sided) else $error("flash drive not one-sided"); // R7

  property p_pulse_train;
    !pin_direction_bit && pulse_train_enable
      |=> o_pin_oe && (o_pin_out == $past(i_pulse_train[pin_function_select]));
  endproperty
  a_pulse_train: assert property (p_pulse_train) else $error("pulse train not followed"); // R13

  property p_edge_is_input;
    sel_edge |-> pin_direction_bit && (filt_rise || filt_fall);
  endproperty
  a_edge_is_input: assert property (p_edge_is_input) else $error("edge taken while output"); // R8

  property p_edge_filtered;
    sel_edge |-> $changed(filt_level);
  endproperty
  a_edge_filtered: assert property (p_edge_filtered) else $error("edge without filter change"); // R9

  sequence s_event_unmasked;
    sel_edge && mask_q[gpio_pin_pkg::IRQ_EDGE_BIT] && !i_wr_en;
  endsequence

  sequence s_int_low;
    status_q[gpio_pin_pkg::IRQ_EDGE_BIT] ##1 !o_int_n;
  endsequence

  property p_irq_raised;
    s_event_unmasked |=> s_int_low;
  endproperty
  a_irq_raised: assert property (p_irq_raised) else $error("interrupt not raised"); // R10

  property p_src_loaded;
    sel_edge |=> src_q == SRC_ADDR;
  endproperty
  a_src_loaded: assert property (p_src_loaded) else $error("source status not loaded"); // R11

  property p_reset_input;
    $rose(i_rst_n) |-> pin_direction_bit;
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pin not input after reset"); // R15

  // Write-one-clear drops the event bit only when no new event lands in that cycle.
  property p_status_clear;
    stat_clear && !sel_edge |=> !status_q[gpio_pin_pkg::IRQ_EDGE_BIT];
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status bit not cleared"); // R10

  // A clear racing an event must never lose the event, or software would miss an edge.
  property p_set_wins;
    sel_edge && stat_clear |=> status_q[gpio_pin_pkg::IRQ_EDGE_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to a clear"); // R10

  // The interrupt pin follows the pending unmasked events one cycle late.
  property p_int_pending;
    |(status_q & mask_q) |=> !o_int_n;
  endproperty
  a_int_pending: assert property (p_int_pending) else $error("interrupt missing"); // R10

  property p_int_idle;
    !(|(status_q & mask_q)) |=> o_int_n;
  endproperty
  a_int_idle: assert property (p_int_idle) else $error("interrupt without event"); // R10

  // Each selected edge kind must be taken whenever the filter reports it.
  property p_rise_taken;
    pin_direction_bit && pin_function_select == gpio_pin_pkg::EDGE_RISE && filt_rise
      |-> sel_edge;
  endproperty
  a_rise_taken: assert property (p_rise_taken) else $error("rising edge missed"); // R8

  property p_fall_taken;
    pin_direction_bit && pin_function_select == gpio_pin_pkg::EDGE_FALL && filt_fall
      |-> sel_edge;
  endproperty
  a_fall_taken: assert property (p_fall_taken) else $error("falling edge missed"); // R8

  property p_any_taken;
    pin_direction_bit && pin_function_select == gpio_pin_pkg::EDGE_ANY && (filt_rise || filt_fall)
      |-> sel_edge;
  endproperty
  a_any_taken: assert property (p_any_taken) else $error("edge missed"); // R8

  property p_output_quiet;
    !pin_direction_bit |-> !sel_edge;
  endproperty
  a_output_quiet: assert property (p_output_quiet) else $error("event while output"); // R4

  // An input reads back the filtered pin level, an output the stored value.
  property p_read_pin_level;
    i_rd_en && i_addr == gpio_pin_pkg::CTRL_OFS && pin_direction_bit
      |=> o_rdata[gpio_pin_pkg::CTRL_VALUE_BIT] == $past(filt_level);
  endproperty
  a_read_pin_level: assert property (p_read_pin_level) else $error("input level misread"); // R5

  property p_read_value_bit;
    i_rd_en && i_addr == gpio_pin_pkg::CTRL_OFS && !pin_direction_bit
      |=> o_rdata[gpio_pin_pkg::CTRL_VALUE_BIT] == $past(pin_output_value);
  endproperty
  a_read_value_bit: assert property (p_read_value_bit) else $error("value bit misread"); // R14

  // Bypass bits are never kept, so the pin cannot enter a mode this block lacks.
  property p_ctrl_reserved;
    wr_ctrl |=> (ctrl_q & ~gpio_pin_pkg::CTRL_WR_MASK) == gpio_pin_pkg::ZERO_BYTE;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("bypass bits kept"); // R1

  property p_ctrl_written;
    wr_ctrl |=> ctrl_q == ($past(i_wdata) & gpio_pin_pkg::CTRL_WR_MASK);
  endproperty
  a_ctrl_written: assert property (p_ctrl_written) else $error("control write lost"); // R3

  // A driven pin must not fight its own weak pull-up.
  property p_pull_off;
    !pin_direction_bit |=> !o_pull_up_en;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull-up on while output"); // R4

  // The source register is never cleared by hardware once loaded.
  property p_src_held;
    !sel_edge && src_q == SRC_ADDR |=> src_q == SRC_ADDR;
  endproperty
  a_src_held: assert property (p_src_held) else $error("source status lost"); // R11

endmodule

/* sim/pin_partner.sv */
// Purpose: Pin-side model of an LED or signal line wired to the pad.
// Assumes: An external resistor pulls the line to the level its one-sided driver never drives.
// Notes:   The bench may drive the line itself to act as an external source.
`timescale 1ns/1ps
module pin_partner (
  input  wire logic i_out,
  input  wire logic i_oe,
  input  wire logic i_pull_up_en,
  input  wire logic i_ext_en,
  input  wire logic i_ext_val,
  output logic      o_level
);
  // The pad wins over the bench; a released line rests high on the pull-up, else opposite the level driven.
  always_comb begin
    if (i_oe) begin
      o_level = i_out;
    end else if (i_ext_en) begin
      o_level = i_ext_val;
    end else if (i_pull_up_en) begin
      o_level = 1'b1;
    end else begin
      // Open-source rests on its pull-down, open-drain on its pull-up.
      o_level = ~i_out;
    end
  end
endmodule

/* sim/per_pin_function_and_edge_irq_tb.sv */
// Purpose: Self-checking bench for the per-pin control block.
// Assumes: Pin model on the pad side, bench as register master.
// Notes:   The flash check waits up to one prescaler half period for the next flash toggle.
`timescale 1ns/1ps
module per_pin_function_and_edge_irq_tb;
  logic       i_clk;
  logic       i_rst_n;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr_en;
  logic       i_rd_en;
  logic [7:0] o_rdata;
  logic [7:0] i_pulse_train;
  logic       pin_lvl;
  logic       o_pin_out;
  logic       o_pin_oe;
  logic       o_pull_up_en;
  logic       o_int_n;
  logic       ext_en;
  logic       ext_val;
  int         errors;
  int         checked;
  logic [23:0] ncyc;

  // Bench timebase, cleared by the same reset as the flash prescaler.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ncyc <= 24'h00_0000;
    end else begin
      ncyc <= ncyc + 24'h00_0001;
    end
  end

  gpio_pin_ctrl #(.SRC_ADDR(8'h90)) uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rdata(o_rdata),
    .i_pulse_train(i_pulse_train), .i_pin_in(pin_lvl), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_pull_up_en(o_pull_up_en), .o_int_n(o_int_n)
  );

  pin_partner p (
    .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pull_up_en(o_pull_up_en),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pin_lvl)
  );

  // Core clock at 25 MHz.
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic summarize();
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr_en <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1;
    chk(nm, e, o_rdata);
  endtask

  task automatic pin(input logic en, input logic v);
    @(posedge i_clk);
    ext_en  <= en;
    ext_val <= v;
  endtask

  task automatic t_reset();
    chk("oe", 8'h00, {7'h0, o_pin_oe});
    chk("pull", 8'h01, {7'h0, o_pull_up_en});
    chk("int_n", 8'h01, {7'h0, o_int_n});
    rchk("ctrl", gpio_pin_pkg::CTRL_OFS, 8'h03);
    rchk("src", gpio_pin_pkg::SRC_OFS, 8'h00);
    wr(8'h10, 8'hFF);
    rchk("unmapped", 8'h10, 8'h00);
    rchk("ctrl_kept", gpio_pin_pkg::CTRL_OFS, 8'h03);
  endtask

  task automatic t_steady();
    wr(gpio_pin_pkg::CTRL_OFS, 8'h00);
    cyc(3);
    chk("oe", 8'h01, {7'h0, o_pin_oe});
    chk("out", 8'h00, {7'h0, o_pin_out});
    wr(gpio_pin_pkg::CTRL_OFS, 8'h61);
    cyc(3);
    chk("out", 8'h01, {7'h0, o_pin_out});
    rchk("ctrl", gpio_pin_pkg::CTRL_OFS, 8'h01);
  endtask

  task automatic t_train();
    for (int k = 0; k < 8; k++) begin
      wr(gpio_pin_pkg::CTRL_OFS, {1'b1, 2'b00, 3'(k), 2'b00});
      @(posedge i_clk);
      i_pulse_train <= 8'h01 << k;
      cyc(4);
      chk("train_hi", 8'h03, {6'h0, o_pin_oe, o_pin_out});
      @(posedge i_clk);
      i_pulse_train <= ~(8'h01 << k);
      cyc(4);
      chk("train_lo", 8'h02, {6'h0, o_pin_oe, o_pin_out});
    end
  endtask

  // Direction is changed alone first, edge selection in later writes.
  task automatic t_edges();
    logic f;
    logic r;
    wr(gpio_pin_pkg::CTRL_OFS, 8'h02);
    cyc(4);
    wr(gpio_pin_pkg::IRQ_STAT_OFS, 8'h01);
    wr(gpio_pin_pkg::IRQ_MASK_OFS, 8'h01);
    for (int s = 0; s < 8; s++) begin
      f = (s == 2 || s == 3);
      r = (s == 1 || s == 3);
      wr(gpio_pin_pkg::CTRL_OFS, {3'b000, 3'(s), 2'b10});
      pin(1'b1, 1'b0);
      cyc(5);
      chk("int_n", {7'h0, ~f}, {7'h0, o_int_n});
      rchk("fall", gpio_pin_pkg::IRQ_STAT_OFS, {7'h0, f});
      if (s == 1) rchk("src_idle", gpio_pin_pkg::SRC_OFS, 8'h00);
      wr(gpio_pin_pkg::IRQ_STAT_OFS, 8'h01);
      pin(1'b1, 1'b1);
      cyc(5);
      rchk("rise", gpio_pin_pkg::IRQ_STAT_OFS, {7'h0, r});
      if (s == 1) rchk("src", gpio_pin_pkg::SRC_OFS, 8'h90);
      wr(gpio_pin_pkg::IRQ_STAT_OFS, 8'h01);
      cyc(2);
      chk("int_n_clr", 8'h01, {7'h0, o_int_n});
    end
  endtask

  task automatic t_glitch_mask();
    wr(gpio_pin_pkg::CTRL_OFS, 8'h0E);
    wr(gpio_pin_pkg::IRQ_MASK_OFS, 8'h00);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    cyc(5);
    rchk("glitch", gpio_pin_pkg::IRQ_STAT_OFS, 8'h00);
    pin(1'b1, 1'b0);
    cyc(5);
    chk("masked", 8'h01, {7'h0, o_int_n});
    rchk("level", gpio_pin_pkg::CTRL_OFS, 8'h0E);
    wr(gpio_pin_pkg::IRQ_MASK_OFS, 8'h01);
    cyc(3);
    chk("unmasked", 8'h00, {7'h0, o_int_n});
    wr(gpio_pin_pkg::IRQ_STAT_OFS, 8'h01);
    cyc(3);
    chk("cleared", 8'h01, {7'h0, o_int_n});
    pin(1'b0, 1'b0);
  endtask

  // Open-drain flash drives only low until its enable toggles; with the value bit set it then drives high.
  task automatic t_flash();
    logic o;
    wr(gpio_pin_pkg::CTRL_OFS, 8'h04);
    cyc(3);
    o = o_pin_oe;
    for (int n = 0; n < 70000; n++) begin
      cyc(1);
      if (o_pin_out !== 1'b0) chk("drain_out", 8'h00, {7'h0, o_pin_out});
      if (o_pin_oe !== o) begin
        chk("flash", {7'h0, ~o}, {7'h0, o_pin_oe});
        chk("flash_at", 8'h01, {7'h0, ncyc[15:0] == 16'h0001});
        wr(gpio_pin_pkg::CTRL_OFS, 8'h05);
        cyc(3);
        chk("source", 8'h03, {6'h0, o_pin_oe, o_pin_out});
        return;
      end
    end
    errors++;
  endtask

  // Reset for four cycles, then each scenario in turn.
  initial begin
    errors = 0;
    checked = 0;
    i_rst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_pulse_train = 8'h00;
    ext_en = 1'b0;
    ext_val = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_steady();
    t_train();
    t_edges();
    t_glitch_mask();
    t_flash();
    summarize();
  end
endmodule
